// ---- hw/exec_pkg.sv ----
// Constants and types shared by the rotate, subtract and power-down datapath.
`default_nettype none
package exec_pkg;
  // ----------------------------------------------------------------
  // Bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_FADDR = 8'h0C;
  localparam logic [7:0] OFS_FDATA = 8'h10;
  localparam logic [7:0] OFS_WDOG = 8'h14;
  localparam logic [7:0] OFS_SLEEP = 8'h18;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int OP_LSB = 0;
  localparam int DEST_BIT = 2;
  localparam int LIT_LSB = 8;
  localparam int FIDX_LSB = 16;
  localparam int FIDX_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ----------------------------------------------------------------
  // Status bit positions and reset value
  // ----------------------------------------------------------------
  localparam int ST_C = 0;
  localparam int ST_NC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_W = 5;
  localparam logic [4:0] STAT_RST = 5'h18;
  localparam int WAKE_BIT = 0;

  // ----------------------------------------------------------------
  // Watchdog geometry
  // ----------------------------------------------------------------
  localparam int WDOG_W = 8;
  localparam int PRESC_W = 8;

  // ----------------------------------------------------------------
  // Operations and run state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ROTATE_LEFT_CARRY_OP = 2'h0,
    ROTATE_RIGHT_CARRY_OP = 2'h1,
    LITERAL_MINUS_ACC_OP = 2'h2,
    POWERDOWN_OP = 2'h3
  } op_e;
  typedef enum logic {
    RUN_ST = 1'b0,
    SLEEP_ST = 1'b1
  } run_e;
endpackage
`default_nettype wire

// ---- hw/exec_alu.sv ----
// Combinational result and flag logic for rotate and subtract operations.
`timescale 1ns/1ps
`default_nettype none
module exec_alu (
  input wire exec_pkg::op_e i_op,
  input wire logic i_carry,
  input wire logic [7:0] i_fval,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_lit,
  output logic [7:0] o_res,
  output logic o_carry,
  output logic o_nibble_carry,
  output logic o_zero
);
  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic is_sub;
  logic is_rl;

  // Nine-bit and five-bit differences expose the borrow out of bit 7 and bit 3.
  assign diff = {1'b0, i_lit} - {1'b0, i_acc};
  assign ndiff = {1'b0, i_lit[3:0]} - {1'b0, i_acc[3:0]};
  assign is_sub = (i_op == exec_pkg::LITERAL_MINUS_ACC_OP);
  assign is_rl = (i_op == exec_pkg::ROTATE_LEFT_CARRY_OP);

  // Carry flags mean no borrow; rotates pass the shifted-out bit.
  assign o_res = is_sub ? diff[7:0] :
                 is_rl ? {i_fval[6:0], i_carry} : {i_carry, i_fval[7:1]};
  assign o_carry = is_sub ? ~diff[8] : (is_rl ? i_fval[7] : i_fval[0]);
  assign o_nibble_carry = ~ndiff[4];
  assign o_zero = (diff[7:0] == 8'h00);
endmodule // exec_alu
`default_nettype wire

// ---- hw/wdog_timer.sv ----
// Watchdog counter with its prescaler and a clear input.
`timescale 1ns/1ps
`default_nettype none
module wdog_timer #(
  parameter int CNT_W = exec_pkg::WDOG_W,
  parameter int PRE_W = exec_pkg::PRESC_W
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_clear,
  output logic [CNT_W-1:0] o_count,
  output logic [PRE_W-1:0] o_presc,
  output logic o_ovf
);
  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic [PRE_W-1:0] presc_q;
  logic [CNT_W-1:0] count_q;
  logic ovf_q;
  logic tick;

  // The prescaler rolls over into one counter step.
  assign tick = &presc_q;

  // Clear forces both stages to zero and masks the overflow.
  always_ff @(posedge i_clk) begin
    if (i_srst || i_clear) begin
      presc_q <= '0;
      count_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 1'b1;
      count_q <= tick ? count_q + 1'b1 : count_q;
      ovf_q <= tick && (&count_q);
    end
  end

  assign o_count = count_q;
  assign o_presc = presc_q;
  assign o_ovf = ovf_q;
endmodule // wdog_timer
`default_nettype wire

// ---- hw/exec_core.sv ----
// AXI4-Lite register front end and execution unit for four core operations.
//
// Contract
// - Rotate left through carry, only carry changes.
// - Rotate left: dest 0 acc, 1 file.
// - Rotate right through carry, only carry changes.
// - Rotate right: dest 0 acc, 1 file.
// - Power-down clears watchdog counter and prescaler.
// - Power-down: powerdown flag 0, timeout flag 1.
// - Power-down halts oscillator and stops execution.
// - Literal minus acc into acc, carry flags.
`timescale 1ns/1ps
`default_nettype none
module exec_core #(
  parameter int DEPTH = exec_pkg::FILE_DEPTH
) (
  input wire logic I_CLK_SYS,
  input wire logic I_SRST,
  input wire logic [7:0] I_AXI_AWADDR,
  input wire logic I_AXI_AWVALID,
  output logic O_AXI_AWREADY,
  input wire logic [31:0] I_AXI_WDATA,
  input wire logic [3:0] I_AXI_WSTRB,
  input wire logic I_AXI_WVALID,
  output logic O_AXI_WREADY,
  output logic [1:0] O_AXI_BRESP,
  output logic O_AXI_BVALID,
  input wire logic I_AXI_BREADY,
  input wire logic [7:0] I_AXI_ARADDR,
  input wire logic I_AXI_ARVALID,
  output logic O_AXI_ARREADY,
  output logic [31:0] O_AXI_RDATA,
  output logic [1:0] O_AXI_RRESP,
  output logic O_AXI_RVALID,
  input wire logic I_AXI_RREADY,
  output logic O_OSC_HALT
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic aw_rdy_q, w_rdy_q, ar_rdy_q;
  logic aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] acc_q;
  logic [exec_pkg::ST_W-1:0] stat_q;
  logic [exec_pkg::FIDX_W-1:0] faddr_q;
  logic [7:0] file_q [DEPTH];
  exec_pkg::run_e run_q;
  logic halt_q;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_fire, wr_map;
  logic hit_instr, hit_acc, hit_stat, hit_faddr, hit_fdata, hit_sleep;
  logic [31:0] wword;
  // A write completes once address and data are both held.
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wword = merge(32'h0000_0000, w_data_q, w_strb_q);
  assign hit_instr = (aw_addr_q == exec_pkg::OFS_INSTR);
  assign hit_acc = (aw_addr_q == exec_pkg::OFS_ACC);
  assign hit_stat = (aw_addr_q == exec_pkg::OFS_STAT);
  assign hit_faddr = (aw_addr_q == exec_pkg::OFS_FADDR);
  assign hit_fdata = (aw_addr_q == exec_pkg::OFS_FDATA);
  assign hit_sleep = (aw_addr_q == exec_pkg::OFS_SLEEP);
  assign wr_map = hit_instr || hit_acc || hit_stat || hit_faddr ||
                  hit_fdata || hit_sleep || (aw_addr_q == exec_pkg::OFS_WDOG);

  // ----------------------------------------------------------------
  // Instruction fields and issue
  // ----------------------------------------------------------------
  exec_pkg::op_e op;
  logic dest, issue;
  logic [7:0] lit, fval, res;
  logic [exec_pkg::FIDX_W-1:0] fidx;
  logic alu_c, alu_nc, alu_z;
  // Instructions written while asleep are dropped.
  assign issue = wr_fire && hit_instr && (run_q == exec_pkg::RUN_ST);
  assign op = exec_pkg::op_e'(wword[exec_pkg::OP_LSB +: 2]);
  assign dest = wword[exec_pkg::DEST_BIT];
  assign lit = wword[exec_pkg::LIT_LSB +: 8];
  assign fidx = wword[exec_pkg::FIDX_LSB +: exec_pkg::FIDX_W];
  assign fval = file_q[fidx];

  exec_alu u_alu (
    .i_op(op),
    .i_carry(stat_q[exec_pkg::ST_C]),
    .i_fval(fval),
    .i_acc(acc_q),
    .i_lit(lit),
    .o_res(res),
    .o_carry(alu_c),
    .o_nibble_carry(alu_nc),
    .o_zero(alu_z)
  );

  // Operation class wires used by the state updates.
  logic is_rot, is_sub, is_pd, to_acc, to_file;
  assign is_rot = issue && (op == exec_pkg::ROTATE_LEFT_CARRY_OP ||
                            op == exec_pkg::ROTATE_RIGHT_CARRY_OP);
  assign is_sub = issue && (op == exec_pkg::LITERAL_MINUS_ACC_OP);
  assign is_pd = issue && (op == exec_pkg::POWERDOWN_OP);
  assign to_acc = is_sub || (is_rot && dest == exec_pkg::DEST_ACC);
  assign to_file = is_rot && dest == exec_pkg::DEST_FILE;

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  logic [exec_pkg::WDOG_W-1:0] wd_count;
  logic [exec_pkg::PRESC_W-1:0] wd_presc;
  logic wd_ovf;
  wdog_timer u_wdog (
    .i_clk(I_CLK_SYS),
    .i_srst(I_SRST),
    .i_clear(is_pd),
    .o_count(wd_count),
    .o_presc(wd_presc),
    .o_ovf(wd_ovf)
  );

  // ----------------------------------------------------------------
  // Next state of accumulator, status and run state
  // ----------------------------------------------------------------
  logic [7:0] acc_d;
  logic [exec_pkg::ST_W-1:0] stat_d;
  logic [exec_pkg::ST_W-1:0] stat_sw;
  logic wake;
  logic [31:0] acc_wr;
  // Unstrobed accumulator bytes keep their old value.
  assign acc_wr = merge({24'h00_0000, acc_q}, w_data_q, w_strb_q);
  assign acc_d = to_acc ? res : (wr_fire && hit_acc) ? acc_wr[7:0] : acc_q;
  assign stat_sw = (wr_fire && hit_stat) ? wword[exec_pkg::ST_W-1:0] : stat_q;
  assign wake = (wr_fire && hit_sleep && wword[exec_pkg::WAKE_BIT]) || wd_ovf;

  // Flag updates; an overflow beats a software write, power-down beats both.
  always_comb begin
    stat_d = stat_sw;
    if (wd_ovf) begin
      stat_d[exec_pkg::ST_TO] = 1'b0;
    end
    if (is_rot) begin
      stat_d[exec_pkg::ST_C] = alu_c;
    end
    if (is_sub) begin
      stat_d[exec_pkg::ST_C] = alu_c;
      stat_d[exec_pkg::ST_NC] = alu_nc;
      stat_d[exec_pkg::ST_Z] = alu_z;
    end
    if (is_pd) begin
      stat_d[exec_pkg::ST_PD] = 1'b0;
      stat_d[exec_pkg::ST_TO] = 1'b1;
    end
  end

  // Architectural registers update in the issue cycle.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      acc_q <= 8'h00;
      stat_q <= exec_pkg::STAT_RST;
      faddr_q <= '0;
    end else begin
      acc_q <= acc_d;
      stat_q <= stat_d;
      if (wr_fire && hit_faddr) begin
        faddr_q <= wword[exec_pkg::FIDX_W-1:0];
      end
    end
  end

  // File registers take rotate results or software writes.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      for (int i = 0; i < DEPTH; i++) begin
        file_q[i] <= 8'h00;
      end
    end else if (to_file) begin
      file_q[fidx] <= res;
    end else if (wr_fire && hit_fdata) begin
      file_q[faddr_q] <= wword[7:0];
    end
  end

  // Power-down stops the oscillator until a wake event.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      run_q <= exec_pkg::RUN_ST;
      halt_q <= 1'b0;
    end else if (is_pd) begin
      run_q <= exec_pkg::SLEEP_ST;
      halt_q <= 1'b1;
    end else if (wake) begin
      run_q <= exec_pkg::RUN_ST;
      halt_q <= 1'b0;
    end
  end
  assign O_OSC_HALT = halt_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  // Address and data are latched independently, then answered together.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= exec_pkg::RESP_OKAY;
    end else begin
      if (I_AXI_AWVALID && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        aw_full_q <= 1'b1;
        aw_addr_q <= {I_AXI_AWADDR[7:2], 2'h0};
      end
      if (I_AXI_WVALID && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        w_full_q <= 1'b1;
        w_data_q <= I_AXI_WDATA;
        w_strb_q <= I_AXI_WSTRB;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_map ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
      if (bvalid_q && I_AXI_BREADY) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q <= 1'b1;
      end
    end
  end
  assign O_AXI_AWREADY = aw_rdy_q;
  assign O_AXI_WREADY = w_rdy_q;
  assign O_AXI_BVALID = bvalid_q;
  assign O_AXI_BRESP = bresp_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  logic [7:0] ra;
  logic [31:0] rd_word;
  logic rd_map;
  assign ra = {I_AXI_ARADDR[7:2], 2'h0};
  assign rd_map = (ra <= exec_pkg::OFS_SLEEP);
  // Read selection; the watchdog word shows counter and prescaler.
  assign rd_word =
    (ra == exec_pkg::OFS_ACC) ? {24'h00_0000, acc_q} :
    (ra == exec_pkg::OFS_STAT) ? {27'h000_0000, stat_q} :
    (ra == exec_pkg::OFS_FADDR) ? {25'h000_0000, faddr_q} :
    (ra == exec_pkg::OFS_FDATA) ? {24'h00_0000, file_q[faddr_q]} :
    (ra == exec_pkg::OFS_WDOG) ? {16'h0000, wd_presc, wd_count} :
    (ra == exec_pkg::OFS_SLEEP) ? {31'h0000_0000, run_q == exec_pkg::SLEEP_ST} :
    32'h0000_0000;

  // One read in flight; data is captured at the address handshake.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= exec_pkg::RESP_OKAY;
    end else if (I_AXI_ARVALID && ar_rdy_q) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_map ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
    end else if (rvalid_q && I_AXI_RREADY) begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end
  assign O_AXI_ARREADY = ar_rdy_q;
  assign O_AXI_RVALID = rvalid_q;
  assign O_AXI_RDATA = rdata_q;
  assign O_AXI_RRESP = rresp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic rl, rr;
  assign rl = issue && op == exec_pkg::ROTATE_LEFT_CARRY_OP;
  assign rr = issue && op == exec_pkg::ROTATE_RIGHT_CARRY_OP;

  property p_rl_flags;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    rl && !wd_ovf |=> stat_q[exec_pkg::ST_C] == $past(fval[7]) &&
      stat_q[exec_pkg::ST_Z:exec_pkg::ST_NC] == $past(stat_q[2:1]);
  endproperty
  a_rl_flags: assert property (p_rl_flags) else $error("rotate left carry wrong");

  property p_rl_acc;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    rl && !dest |=> acc_q == {$past(fval[6:0]), $past(stat_q[0])} &&
      file_q[$past(fidx)] == $past(fval);
  endproperty
  a_rl_acc: assert property (p_rl_acc) else $error("rotate left to acc wrong");

  property p_rr_flags;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    rr && !wd_ovf |=> stat_q[exec_pkg::ST_C] == $past(fval[0]) &&
      $stable(stat_q[exec_pkg::ST_Z:exec_pkg::ST_NC]);
  endproperty
  a_rr_flags: assert property (p_rr_flags) else $error("rotate right carry wrong");

  property p_rr_file;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    rr && dest |=> file_q[$past(fidx)] == {$past(stat_q[0]), $past(fval[7:1])} &&
      $stable(acc_q);
  endproperty
  a_rr_file: assert property (p_rr_file) else $error("rotate right to file wrong");

  property p_pd_wdog;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    is_pd |=> wd_count == '0 && wd_presc == '0 ##1 wd_presc == 8'h01;
  endproperty
  a_pd_wdog: assert property (p_pd_wdog) else $error("watchdog not cleared");

  property p_pd_flags;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    is_pd |=> !stat_q[exec_pkg::ST_PD] && stat_q[exec_pkg::ST_TO] &&
      stat_q[exec_pkg::ST_Z:exec_pkg::ST_C] == $past(stat_q[2:0]);
  endproperty
  a_pd_flags: assert property (p_pd_flags) else $error("power-down flags wrong");

  property p_pd_halt;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    is_pd |=> O_OSC_HALT && run_q == exec_pkg::SLEEP_ST && !issue;
  endproperty
  a_pd_halt: assert property (p_pd_halt) else $error("oscillator not halted");

  property p_sub;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    is_sub && !wd_ovf |=> acc_q == 8'($past(lit) - $past(acc_q)) &&
      stat_q[exec_pkg::ST_C] == ($past(lit) >= $past(acc_q)) &&
      stat_q[exec_pkg::ST_NC] == ($past(lit[3:0]) >= $past(acc_q[3:0]));
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result or carry wrong");

  property p_sub_zero;
    @(posedge I_CLK_SYS) disable iff (I_SRST)
    is_sub |=> stat_q[exec_pkg::ST_Z] == (acc_q == 8'h00);
  endproperty
  a_sub_zero: assert property (p_sub_zero) else $error("zero flag wrong");
endmodule // exec_core
`default_nettype wire

// ---- bench/axil_master_model.sv ----
// Bus master model that issues single register transfers to the execution core.
`timescale 1ns/1ps
`default_nettype none
module axil_master_model (
  input wire logic i_clk,
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic o_rready,
  output logic o_hang
);
  // Byte strobes offered with every write; the bench may narrow them.
  logic [3:0] strb_sel;

  // All channels start idle.
  initial begin
    o_awaddr = 8'h00;
    o_awvalid = 1'b0;
    o_wdata = 32'h0;
    o_wstrb = 4'h0;
    o_wvalid = 1'b0;
    o_bready = 1'b0;
    o_araddr = 8'h00;
    o_arvalid = 1'b0;
    o_rready = 1'b0;
    o_hang = 1'b0;
    strb_sel = 4'hF;
  end

  // One write; each channel is dropped at its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    int n;
    done = 0;
    r = 2'h0;
    @(posedge i_clk);
    o_awaddr <= a;
    o_wdata <= d;
    o_wstrb <= strb_sel;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    for (n = 0; n < 200 && !done; n++) begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
      if (i_bvalid) begin
        r = i_bresp;
        o_bready <= 1'b0;
        done = 1;
      end
    end
    if (!done) o_hang <= 1'b1;
  endtask

  // One read; data and response are taken at the edge that sees rvalid.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    int n;
    done = 0;
    d = 32'h0;
    r = 2'h0;
    @(posedge i_clk);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    for (n = 0; n < 200 && !done; n++) begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
      if (i_rvalid) begin
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'b0;
        done = 1;
      end
    end
    if (!done) o_hang <= 1'b1;
  endtask
endmodule // axil_master_model
`default_nettype wire

// ---- bench/rotate_subtract_sleep_exec_tb.sv ----
// Self-checking bench for the rotate, subtract and power-down execution core.
`timescale 1ns/1ps
`default_nettype none
module rotate_subtract_sleep_exec_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hang, halt;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_total, tests_run, i;
  int acc_m, st_m, op, dst, lit, fi, fv, res;

  // 125 MHz core clock.
  always #4 clk = ~clk;

  exec_core dut (.I_CLK_SYS(clk), .I_SRST(srst), .I_AXI_AWADDR(awaddr),
    .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata),
    .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
    .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
    .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
    .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid),
    .I_AXI_RREADY(rready), .O_OSC_HALT(halt));

  axil_master_model m (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
    .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
    .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready), .o_hang(hang));

  // --------------------------------------------------------------
  // Checking and closing helpers
  // --------------------------------------------------------------
  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Register write with an expected response kind.
  task automatic wrx(input logic [7:0] a, input logic [31:0] v, input bit bad);
    m.wr(a, v, r);
    chk(r, bad ? exec_pkg::RESP_SLVERR : exec_pkg::RESP_OKAY);
  endtask

  // Register read compared under a mask.
  task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k, input bit bad);
    m.rd(a, d, r);
    chk(d & k, e);
    chk(r, bad ? exec_pkg::RESP_SLVERR : exec_pkg::RESP_OKAY);
  endtask

  // Reference model of one rotate or subtract; carry is status bit 0.
  task automatic step();
    case (op)
      0: begin
        res = ((fv << 1) | (st_m & 1)) & 255;
        st_m = (st_m & 30) | (fv >> 7);
      end
      1: begin
        res = (fv >> 1) | ((st_m & 1) << 7);
        st_m = (st_m & 30) | (fv & 1);
      end
      default: begin
        res = (lit - acc_m) & 255;
        st_m = (st_m & 24) | (lit >= acc_m ? 1 : 0) | (res == 0 ? 4 : 0);
        st_m = st_m | ((lit & 15) >= (acc_m & 15) ? 2 : 0);
        acc_m = res;
      end
    endcase
    if (op < 2 && dst == 1) fv = res;
    if (op < 2 && dst == 0) acc_m = res;
  endtask

  // A stuck handshake ends the run as a failure.
  always @(posedge hang) begin
    err_total++;
    wrap_up();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  // Reset, decode checks, random operations, then power-down and wake.
  initial begin
    void'($urandom(32'hA5EE));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdx(exec_pkg::OFS_STAT, {27'h0, exec_pkg::STAT_RST}, 32'hFFFFFFFF, 0);
    rdx(exec_pkg::OFS_ACC, 32'h0, 32'hFFFFFFFF, 0);
    rdx(exec_pkg::OFS_SLEEP, 32'h0, 32'hFFFFFFFF, 0);
    chk(halt, 1'b0);
    rdx(8'h1C, 32'h0, 32'hFFFFFFFF, 1);
    wrx(8'h20, 32'h5A, 1);
    for (i = 0; i < 48; i++) begin
      acc_m = $urandom % 256;
      st_m = $urandom % 32;
      fi = $urandom % 128;
      fv = $urandom % 256;
      op = i % 3;
      dst = $urandom % 2;
      lit = (i % 8 == 2) ? acc_m : $urandom % 256;
      wrx(exec_pkg::OFS_ACC, acc_m, 0);
      wrx(exec_pkg::OFS_STAT, st_m, 0);
      wrx(exec_pkg::OFS_FADDR, fi, 0);
      wrx(exec_pkg::OFS_FDATA, fv, 0);
      wrx(exec_pkg::OFS_INSTR, {9'h0, 7'(fi), 8'(lit), 5'h0, 1'(dst), 2'(op)}, 0);
      step();
      rdx(exec_pkg::OFS_ACC, acc_m, 32'hFF, 0);
      rdx(exec_pkg::OFS_STAT, st_m, 32'h1F, 0);
      rdx(exec_pkg::OFS_FDATA, fv, 32'hFF, 0);
    end
    // Partial strobes: the accumulator keeps unstrobed bytes, status takes zeros.
    m.strb_sel = 4'h2;
    wrx(exec_pkg::OFS_ACC, 32'h0000_55FF, 0);
    wrx(exec_pkg::OFS_STAT, 32'h0000_551F, 0);
    m.strb_sel = 4'hF;
    rdx(exec_pkg::OFS_ACC, acc_m, 32'hFF, 0);
    rdx(exec_pkg::OFS_STAT, 32'h0, 32'h1F, 0);
    st_m = $urandom % 32;
    wrx(exec_pkg::OFS_STAT, st_m, 0);
    wrx(exec_pkg::OFS_ACC, 32'h5A, 0);
    repeat (300) @(posedge clk);
    m.rd(exec_pkg::OFS_WDOG, d, r);
    chk(d[7:0] != 8'h00, 1'b1);
    wrx(exec_pkg::OFS_INSTR, 32'h3, 0);
    m.rd(exec_pkg::OFS_WDOG, d, r);
    chk(d[7:0], 8'h00);
    chk(d[15:8] < 8'h10, 1'b1);
    rdx(exec_pkg::OFS_STAT, (st_m & 7) | 16, 32'h1F, 0);
    chk(halt, 1'b1);
    rdx(exec_pkg::OFS_SLEEP, 32'h1, 32'h1, 0);
    wrx(exec_pkg::OFS_INSTR, 32'h5A02, 0);
    rdx(exec_pkg::OFS_ACC, 32'h5A, 32'hFF, 0);
    wrx(exec_pkg::OFS_SLEEP, 32'h1, 0);
    chk(halt, 1'b0);
    rdx(exec_pkg::OFS_SLEEP, 32'h0, 32'h1, 0);
    wrap_up();
  end
endmodule // rotate_subtract_sleep_exec_tb
`default_nettype wire
